// ---- design/mosb_map.svh ----
// Offsets, widths and sizing constants of the store buffer block.
// Assumes byte addresses and a 32-bit data path with four byte lanes.
`ifndef MOSB_MAP_SVH
`define MOSB_MAP_SVH
`define MOSB_ADDR_W 32
`define MOSB_DATA_W 32
`define MOSB_BE_W 4
`define MOSB_DEPTH 8
`define MOSB_BLK_OFS_W 5
`define MOSB_WORD_OFS_W 2
`define MOSB_PARTIAL_WAIT 1
`define MOSB_BE_FULL 4'hf
`endif

// ---- design/mosb_pkg.sv ----
// Types shared by the store buffer block.
// Assumes nothing beyond a SystemVerilog compiler.
package mosb_pkg;
	typedef enum logic [1:0] {
		mosb_idle = 2'b00,
		mosb_ld_wait = 2'b11,
		mosb_ld_rd = 2'b01,
		mosb_bar_wait = 2'b10
	} mosb_state_t;
endpackage

// ---- design/mosb_store_buffer.sv ----
// Store buffer and load/store ordering logic of one coherent processor.
// Assumes the interconnect ports are driven by logic on the same clock.
//
// Overview of operation
// - Stores to different blocks may reach visibility out of program order.
// - A younger load never passes an older load, even to another block.
// - A load may pass buffered older stores to different cache blocks.
// - Accepted stores wait in a local write buffer before draining.
// - Buffered stores may stay invisible indefinitely; loads to other blocks need not wait.
// - A load fully covered by buffered bytes is answered from the buffer.
// - A barrier completes only after every buffered store is visible.
// - Stores after a barrier are held until earlier stores are visible.
// - Loads after a barrier are held until the barrier completes.
// - Dependent loads see older stores; dependent stores follow their loads.
// - Visibility order may differ from the local execution order.
// - Loads returning stale data count as ordered before the later store.
// - Optionally stall partial overlaps instead of forwarding them.
`timescale 1ns/1ps
`include "mosb_map.svh"

module mosb_store_buffer #(
	parameter int ADDR_W = `MOSB_ADDR_W,
	parameter int DEPTH = `MOSB_DEPTH,
	parameter int BLK_OFS_W = `MOSB_BLK_OFS_W,
	parameter bit PARTIAL_WAIT = `MOSB_PARTIAL_WAIT
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic st_valid,
	input wire logic [ADDR_W-1:0] st_addr,
	input wire logic [`MOSB_DATA_W-1:0] st_data,
	input wire logic [`MOSB_BE_W-1:0] st_be,
	output logic st_ready,
	input wire logic ld_valid,
	input wire logic [ADDR_W-1:0] ld_addr,
	input wire logic bar_valid,
	output logic req_ready,
	output logic ld_done,
	output logic [`MOSB_DATA_W-1:0] ld_data,
	output logic bar_done,
	output logic wr_valid,
	output logic [ADDR_W-1:0] wr_addr,
	output logic [`MOSB_DATA_W-1:0] wr_data,
	output logic [`MOSB_BE_W-1:0] wr_be,
	input wire logic wr_ack,
	output logic rd_valid,
	output logic [ADDR_W-1:0] rd_addr,
	input wire logic rd_ack,
	input wire logic [`MOSB_DATA_W-1:0] rd_data
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int DW = `MOSB_DATA_W;
	localparam int BEW = `MOSB_BE_W;

	// Entries must be a power of two so the pointers wrap on their own
	logic [ADDR_W-1:0] buf_addr_q [DEPTH], buf_addr_d [DEPTH];
	logic [DW-1:0] buf_data_q [DEPTH], buf_data_d [DEPTH];
	logic [BEW-1:0] buf_be_q [DEPTH], buf_be_d [DEPTH];
	logic [PW-1:0] head_q, head_d, tail_q, tail_d, idx;
	logic [CW-1:0] count_q, count_d;
	mosb_pkg::mosb_state_t state_q, state_d;
	logic [ADDR_W-1:0] la_q, la_d, wr_addr_q, wr_addr_d, rd_addr_q, rd_addr_d, scan_addr;
	logic [DW-1:0] fw_data_q, fw_data_d, ld_data_q, ld_data_d, wr_data_q, wr_data_d, scan_data;
	logic [BEW-1:0] fw_be_q, fw_be_d, wr_be_q, wr_be_d, scan_be;
	logic st_ready_q, st_ready_d, req_ready_q, req_ready_d, ld_done_q, ld_done_d;
	logic bar_done_q, bar_done_d, wr_valid_q, wr_valid_d, rd_valid_q, rd_valid_d;
	logic st_acc, ld_acc, bar_acc, pop, word_hit, blk_other, blk_hit, full_cover, need_wait;

	function automatic logic [DW-1:0] mosb_merge(input logic [DW-1:0] base,
			input logic [DW-1:0] nw, input logic [BEW-1:0] be);
		logic [DW-1:0] r;
		r = base;
		for (int b = 0; b < BEW; b++) begin
			if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction

	function automatic logic same_blk(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
		return a[ADDR_W-1:BLK_OFS_W] == b[ADDR_W-1:BLK_OFS_W];
	endfunction
	function automatic logic same_word(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
		return a[ADDR_W-1:`MOSB_WORD_OFS_W] == b[ADDR_W-1:`MOSB_WORD_OFS_W];
	endfunction

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	assign {st_ready, req_ready} = {st_ready_q, req_ready_q};
	assign {ld_done, ld_data, bar_done} = {ld_done_q, ld_data_q, bar_done_q};
	assign {wr_valid, wr_addr, wr_data, wr_be} = {wr_valid_q, wr_addr_q, wr_data_q, wr_be_q};
	assign {rd_valid, rd_addr} = {rd_valid_q, rd_addr_q};

	////////////////////////////////////////////////////////////////////////////////
	// Buffer scan: oldest to newest, so younger bytes win the overlay
	always_comb begin
		idx = head_q;
		scan_addr = (state_q == mosb_pkg::mosb_idle) ? ld_addr : la_q;
		{scan_data, scan_be} = '0;
		{word_hit, blk_other} = 2'b00;
		for (int i = 0; i < DEPTH; i++) begin
			idx = head_q + PW'(i);
			if (CW'(i) < count_q) begin
				if (same_word(buf_addr_q[idx], scan_addr)) begin
					word_hit = 1'b1;
					scan_data = mosb_merge(scan_data, buf_data_q[idx], buf_be_q[idx]);
					scan_be = scan_be | buf_be_q[idx];
				end else if (same_blk(buf_addr_q[idx], scan_addr)) begin
					blk_other = 1'b1;
				end
			end
		end
		blk_hit = word_hit || blk_other;
		full_cover = word_hit && (scan_be == `MOSB_BE_FULL);
		// Same block but other word stalls; different blocks pass freely
		need_wait = blk_other || (word_hit && PARTIAL_WAIT);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write buffer storage
	always_comb begin
		buf_addr_d = buf_addr_q;
		buf_data_d = buf_data_q;
		buf_be_d = buf_be_q;
		if (st_acc) begin
			buf_addr_d[tail_q] = st_addr;
			buf_data_d[tail_q] = st_data;
			buf_be_d[tail_q] = st_be;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			buf_addr_q <= '{default: '0};
			buf_data_q <= '{default: '0};
			buf_be_q <= '{default: '0};
		end else begin
			buf_addr_q <= buf_addr_d;
			buf_data_q <= buf_data_d;
			buf_be_q <= buf_be_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control, drain and load sequencing
	always_comb begin
		state_d = state_q;
		{head_d, la_d} = {head_q, la_q};
		{fw_data_d, fw_be_d, ld_data_d} = {fw_data_q, fw_be_q, ld_data_q};
		{ld_done_d, bar_done_d} = 2'b00;
		{wr_valid_d, wr_addr_d} = {wr_valid_q, wr_addr_q};
		{wr_data_d, wr_be_d} = {wr_data_q, wr_be_q};
		{rd_valid_d, rd_addr_d} = {rd_valid_q, rd_addr_q};
		// Program order is store, then load, then barrier within one cycle
		st_acc = st_valid && st_ready_q;
		ld_acc = ld_valid && req_ready_q && !st_acc;
		bar_acc = bar_valid && req_ready_q && !st_acc && !ld_valid;
		pop = wr_valid_q && wr_ack;
		tail_d = tail_q + PW'(st_acc);
		// Entry stays buffered, and forwardable, until the interconnect acks it
		if (pop) begin
			head_d = head_q + PW'(1);
			wr_valid_d = 1'b0;
		end else if (!wr_valid_q && count_q != '0) begin
			// Drains in FIFO order, a legal subset of any block reordering
			{wr_valid_d, wr_addr_d} = {1'b1, buf_addr_q[head_q]};
			{wr_data_d, wr_be_d} = {buf_data_q[head_q], buf_be_q[head_q]};
		end
		count_d = count_q + CW'(st_acc) - CW'(pop);
		unique case (state_q)
			mosb_pkg::mosb_idle: begin
				if (ld_acc) begin
					la_d = ld_addr;
					if (full_cover) begin
						ld_data_d = scan_data;
						ld_done_d = 1'b1;
					end else if (need_wait) begin
						state_d = mosb_pkg::mosb_ld_wait;
					end else begin
						// Bypass without waiting for the buffer to drain
						rd_valid_d = 1'b1;
						rd_addr_d = ld_addr;
						fw_data_d = scan_data;
						fw_be_d = scan_be;
						state_d = mosb_pkg::mosb_ld_rd;
					end
				end else if (bar_acc) begin
					state_d = mosb_pkg::mosb_bar_wait;
				end
			end
			mosb_pkg::mosb_ld_wait: begin
				if (!blk_hit) begin
					rd_valid_d = 1'b1;
					rd_addr_d = la_q;
					fw_data_d = '0;
					fw_be_d = '0;
					state_d = mosb_pkg::mosb_ld_rd;
				end
			end
			mosb_pkg::mosb_ld_rd: begin
				if (rd_ack) begin
					// Fetched data is the coherent order's value for the rest
					rd_valid_d = 1'b0;
					ld_data_d = mosb_merge(rd_data, fw_data_q, fw_be_q);
					ld_done_d = 1'b1;
					state_d = mosb_pkg::mosb_idle;
				end
			end
			mosb_pkg::mosb_bar_wait: begin
				if (count_q == '0 && !wr_valid_q) begin
					bar_done_d = 1'b1;
					state_d = mosb_pkg::mosb_idle;
				end
			end
		endcase
		// Requests are only taken in idle, which keeps loads in order
		st_ready_d = (state_d == mosb_pkg::mosb_idle) && (count_d < CW'(DEPTH));
		req_ready_d = (state_d == mosb_pkg::mosb_idle);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= mosb_pkg::mosb_idle;
			{head_q, tail_q, count_q, la_q, fw_data_q, fw_be_q} <= '0;
			{st_ready_q, req_ready_q, ld_done_q, bar_done_q, wr_valid_q, rd_valid_q} <= '0;
			{ld_data_q, wr_addr_q, wr_data_q, wr_be_q, rd_addr_q} <= '0;
		end else begin
			state_q <= state_d;
			{head_q, tail_q, count_q, la_q} <= {head_d, tail_d, count_d, la_d};
			{fw_data_q, fw_be_q, ld_data_q} <= {fw_data_d, fw_be_d, ld_data_d};
			{st_ready_q, req_ready_q} <= {st_ready_d, req_ready_d};
			{ld_done_q, bar_done_q} <= {ld_done_d, bar_done_d};
			{wr_valid_q, wr_addr_q} <= {wr_valid_d, wr_addr_d};
			{wr_data_q, wr_be_q} <= {wr_data_d, wr_be_d};
			{rd_valid_q, rd_addr_q} <= {rd_valid_d, rd_addr_d};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_bar_drained;
		bar_done_q |-> $past(count_q) == '0 && !$past(wr_valid_q);
	endproperty
	a_bar_drained: assert property (p_bar_drained) else $error("barrier done with stores left");

	property p_bar_holds_st;
		state_q == mosb_pkg::mosb_bar_wait |-> !st_ready_q;
	endproperty
	a_bar_holds_st: assert property (p_bar_holds_st) else $error("store taken during barrier");

	property p_bar_holds_ld;
		bar_acc |=> !req_ready_q throughout (state_q == mosb_pkg::mosb_bar_wait) [*1];
	endproperty
	a_bar_holds_ld: assert property (p_bar_holds_ld) else $error("load taken during barrier");

	property p_fwd;
		ld_acc && full_cover |=> ld_done_q && !rd_valid_q && ld_data_q == $past(scan_data);
	endproperty
	a_fwd: assert property (p_fwd) else $error("covered load not forwarded");

	property p_bypass;
		ld_acc && !blk_hit && count_q != '0 |=> rd_valid_q && rd_addr_q == $past(ld_addr);
	endproperty
	a_bypass: assert property (p_bypass) else $error("load did not bypass buffer");

	property p_wr_hold;
		wr_valid_q && !wr_ack |=> wr_valid_q && $stable(wr_addr_q) && $stable(wr_data_q);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write dropped before ack");

	property p_full;
		count_q == CW'(DEPTH) |-> !st_ready_q;
	endproperty
	a_full: assert property (p_full) else $error("store offered while full");

	property p_wait_rd;
		state_q == mosb_pkg::mosb_ld_wait && !blk_hit |=> rd_valid_q ##0 fw_be_q == '0;
	endproperty
	a_wait_rd: assert property (p_wait_rd) else $error("stalled load not issued");

	property p_merge;
		state_q == mosb_pkg::mosb_ld_rd && rd_ack |=>
			ld_done_q && ld_data_q == mosb_merge($past(rd_data), $past(fw_data_q), $past(fw_be_q));
	endproperty
	a_merge: assert property (p_merge) else $error("merged load data wrong");

	c_fwd: cover property (ld_acc && full_cover);
	c_merge: cover property (state_q == mosb_pkg::mosb_ld_rd && rd_ack && fw_be_q != '0);
	c_bar: cover property (bar_done_q);
	c_full: cover property (count_q == CW'(DEPTH));
endmodule

// ---- test/memory_ordering_store_buffer_bench.sv ----
// Self-checking bench of the store buffer with a random mix of stores, loads, barriers.
// Assumes the memory model and the design share one 100 MHz clock.
`timescale 1ns/1ps
module memory_ordering_store_buffer_bench;
	logic clk = 0, reset_n = 0, st_valid = 0, ld_valid = 0, bar_valid = 0, overlap = 0;
	logic [31:0] st_addr = 0, st_data = 0, ld_addr = 0;
	logic [3:0] st_be = 0, dly = 0;
	logic st_ready, req_ready, ld_done, bar_done, wr_valid, wr_ack, rd_valid, rd_ack;
	logic [31:0] ld_data, wr_addr, wr_data, rd_addr, rd_data;
	logic [3:0] wr_be;
	logic [31:0] ref_m [int];
	int n_mismatch = 0, check_count = 0, cyc = 0;
	mosb_store_buffer dut_u (.clk, .reset_n, .st_valid, .st_addr, .st_data, .st_be, .st_ready,
		.ld_valid, .ld_addr, .bar_valid, .req_ready, .ld_done, .ld_data, .bar_done, .wr_valid,
		.wr_addr, .wr_data, .wr_be, .wr_ack, .rd_valid, .rd_addr, .rd_ack, .rd_data);
	mosb_mem_model partner_u (.clk, .dly, .wr_valid, .wr_addr, .wr_data, .wr_be, .wr_ack,
		.rd_valid, .rd_addr, .rd_ack, .rd_data);
	initial begin
		forever #5 clk = ~clk;
	end
	always @(negedge clk) if (rd_valid && wr_valid) overlap <= 1'b1;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Program-order view of memory, which a single thread must always see
	function automatic logic [31:0] exp_word(input logic [31:0] a);
		return ref_m.exists(a[31:2]) ? ref_m[a[31:2]] : {a[15:0], ~a[15:0]};
	endfunction
	task automatic store(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] w;
		w = exp_word(a);
		@(negedge clk);
		st_valid = 1;
		st_addr = a;
		st_data = d;
		st_be = be;
		// Ready is a register, settled at the falling edge; the next rising edge takes it
		while (st_ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		for (int i = 0; i < 4; i++) if (be[i]) w[8*i+:8] = d[8*i+:8];
		ref_m[a[31:2]] = w;
		@(negedge clk);
		st_valid = 0;
	endtask
	task automatic load(input logic [31:0] a, output int n);
		@(negedge clk);
		ld_valid = 1;
		ld_addr = a;
		while (req_ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		n = 0;
		do begin @(negedge clk); ld_valid = 0; n++; end while (ld_done !== 1'b1);
		chk("ld_data", exp_word(a), ld_data);
	endtask
	task automatic bar();
		@(negedge clk);
		bar_valid = 1;
		while (req_ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		@(negedge clk);
		bar_valid = 0;
		while (bar_done !== 1'b1) begin
			chk("req_ready", 32'h0, {31'h0, req_ready});
			@(negedge clk);
		end
		chk("wr_valid", 32'h0, {31'h0, wr_valid});
		foreach (ref_m[k]) chk("visible", ref_m[k], partner_u.mem[k]);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		int n;
		logic [31:0] a;
		void'($urandom(32'hb46b6ba9));
		repeat (5) @(posedge clk);
		@(negedge clk);
		reset_n = 1;
		repeat (2) @(posedge clk);
		// Slow interconnect keeps stores buffered while loads run
		dly = 4'hc;
		store(32'h04, 32'h11223344, 4'hf);
		store(32'h20, 32'h55667788, 4'hf);
		// Forward first, while the slow write of the first store is still pending
		load(32'h04, n);
		chk("fwd_lat", 32'h1, {31'h0, n <= 2 && wr_valid});
		load(32'h44, n);
		chk("overlap", 32'h1, {31'h0, overlap});
		store(32'h04, 32'haa000000, 4'h8);
		load(32'h04, n);
		load(32'h24, n);
		for (int i = 0; i < 10; i++) store(32'h60 + 4 * i, $urandom, 4'hf);
		bar();
		load(32'h60, n);
		for (int i = 0; i < 400; i++) begin
			dly = 4'($urandom_range(0, 3));
			a = 32'($urandom_range(0, 31)) << 2;
			case ($urandom_range(0, 9))
				0: bar();
				1, 2, 3, 4: store(a, $urandom, 4'($urandom_range(1, 15)));
				default: load(a, n);
			endcase
		end
		bar();
		test_done();
	end
endmodule

// ---- test/mosb_mem_model.sv ----
// Interconnect and memory model facing the store buffer's write and read ports.
// Assumes the design's clock; every answer comes dly plus one cycles after the request.
`timescale 1ns/1ps
module mosb_mem_model (
	input wire logic clk,
	input wire logic [3:0] dly,
	input wire logic wr_valid,
	input wire logic [31:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic [3:0] wr_be,
	output logic wr_ack,
	input wire logic rd_valid,
	input wire logic [31:0] rd_addr,
	output logic rd_ack,
	output logic [31:0] rd_data
);
	logic [31:0] mem [int];
	logic [31:0] w;
	int wc = 0;
	int rc = 0;
	initial begin
		wr_ack = 1'b0;
		rd_ack = 1'b0;
		rd_data = 32'h0;
	end
	function automatic logic [31:0] rd_word(input logic [31:0] a);
		return mem.exists(a[31:2]) ? mem[a[31:2]] : {a[15:0], ~a[15:0]};
	endfunction
	////////////////////////////////////////////////////////////////
	// A write becomes visible at the edge that acknowledges it
	always @(posedge clk) begin
		if (wr_ack) begin
			wr_ack <= 1'b0;
			wc <= 0;
		end else if (wr_valid && wc >= dly) begin
			wr_ack <= 1'b1;
			w = rd_word(wr_addr);
			for (int i = 0; i < 4; i++) if (wr_be[i]) w[8*i+:8] = wr_data[8*i+:8];
			mem[wr_addr[31:2]] = w;
		end else begin
			wc <= wr_valid ? wc + 1 : 0;
		end
	end
	////////////////////////////////////////////////////////////////
	// Read data toggles outside the answer cycle so stale values never match
	always @(posedge clk) begin
		if (rd_ack) begin
			rd_ack <= 1'b0;
			rc <= 0;
			rd_data <= ~rd_data;
		end else if (rd_valid && rc >= dly) begin
			rd_ack <= 1'b1;
			rd_data <= rd_word(rd_addr);
		end else begin
			rc <= rd_valid ? rc + 1 : 0;
			rd_data <= ~rd_data;
		end
	end
endmodule
